// [logic/sas_defs.svh]
// Register offsets, field positions, reset values and timing counts of the converter sequencer.
//
// Contract
// - Each sample resolves by successive approximation into 10 bits in the result pair.
// - All inputs share one sample-and-hold feeding the converter through a multiplexer.
// - Channel select picks one of 14 sources: twelve pins, temperature, reference buffer.
// - Positive reference is external pin or supply; negative reference is always ground.
// - Clock select codes give osc /2,/4,/8,/16,/32,/64; x11 picks internal RC.
// - A full conversion takes 11.5 bit-conversion periods of the selected clock.
// - Oscillator-derived conversion clocks follow the system clock; only RC is independent.
// - Converter runs in Sleep only with the internal RC clock selected.
// - Completion flag sets on every conversion; only a software write clears it.
// - Interrupt request raised when completion flag and its enable are both set.
// - Completion interrupt wakes from Sleep; vectoring needs global and peripheral enables.
// - Justify bit 0 left-justifies, 1 right-justifies; unused result bits read zero.
// - Converter enabled only while module-on is 1; writing start/done 1 starts.
// - On completion clear start/done, set the flag, load both result registers.
// - Clearing start/done mid-conversion stops it; unresolved bits copy last resolved bit.
// - Reset restores all registers, switches module off, cancels any conversion.
// - Sleep with an oscillator clock aborts conversion and turns converter off; on stays.
// - Finishing in Sleep with interrupt disabled turns converter off; module-on stays set.
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SAS_OFF_CTRL      5'h00
`define SAS_OFF_CFG       5'h04
`define SAS_OFF_RES_HIGH  5'h08
`define SAS_OFF_RES_LOW   5'h0C
`define SAS_OFF_IRQ       5'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SAS_CTRL_ON       0
`define SAS_CTRL_GO       1
`define SAS_CTRL_CH_LO    2
`define SAS_CTRL_CH_HI    6
`define SAS_CFG_PREF      0
`define SAS_CFG_CS_LO     4
`define SAS_CFG_CS_HI     6
`define SAS_CFG_JUSTIFY   7
`define SAS_IRQ_FLAG      0
`define SAS_IRQ_EN        1
`define SAS_IRQ_GIE       2
`define SAS_IRQ_PERIPH_IRQ_ENABLE      3

// ----------------------------------------------------------------------------
// Reset values and channel codes
// ----------------------------------------------------------------------------
`define SAS_RST_BYTE      8'h00
`define SAS_CH_PINS       5'h0C
`define SAS_CH_TEMP       5'h1D
`define SAS_CH_REFBUF     5'h1E

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SAS_CLK_MHZ       25
`define SAS_TEMP_SETTLE_US 200
`define SAS_TEMP_SETTLE_CYC (`SAS_TEMP_SETTLE_US * `SAS_CLK_MHZ)

`endif

// [logic/sas_pkg.sv]
// Types shared by the converter sequencer files.
package sas_pkg;

    typedef enum logic [1:0] {
        SAS_IDLE  = 2'b00,
        SAS_HOLD  = 2'b01,
        SAS_BITS  = 2'b10,
        SAS_FINAL = 2'b11
    } sas_state_t;

    typedef struct packed {
        logic        powered;
        logic        sample;
        logic [13:0] mux_sel;
        logic        ref_ext;
        logic [9:0]  trial;
    } sas_ana_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } sas_result_t;

endpackage : sas_pkg

// [logic/sas_clkdiv.sv]
// Conversion clock divider producing a half-period enable pulse.
`timescale 1ns/100ps
module sas_clkdiv
    import sas_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    input  wire logic       rc_edge,
    output logic            half_tick
);

    // Half-period length minus one: codes 000,100,001,101,010,110 map to 1..32 cycles.
    function automatic logic [4:0] half_limit(input logic [2:0] sel);
        logic [5:0] span;
        span = 6'h01 << {sel[1:0], sel[2]};
        return 5'(span - 6'h01);
    endfunction : half_limit

    logic [4:0] cnt;
    wire        rc_sel = (clk_sel[1:0] == 2'b11);
    wire  [4:0] limit  = half_limit(clk_sel);
    wire        wrap   = (cnt == limit);

    // The count runs on sys_clk itself, so it follows any change in its rate.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 5'h00;
        end else if (!run || wrap || rc_sel) begin
            cnt <= 5'h00;
        end else begin
            cnt <= cnt + 5'h01;
        end
    end

    assign half_tick = run & (rc_sel ? rc_edge : wrap);

endmodule : sas_clkdiv

// [logic/sas_sar.sv]
// Successive-approximation sequencer: sample, resolve bits, flag the end.
`timescale 1ns/100ps
module sas_sar
    import sas_pkg::*;
#(
    parameter int WIDTH = 10
)(
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             half_tick,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             comp,
    output logic                  busy,
    output logic                  done,
    output logic                  sample,
    output logic [WIDTH-1:0]      trial,
    output logic [WIDTH-1:0]      value
);

    localparam int IW = $clog2(WIDTH);
    localparam logic [IW-1:0] TOP = IW'(WIDTH - 1);

    function automatic logic [WIDTH-1:0] put_bit(input logic [WIDTH-1:0] v,
                                                 input logic [IW-1:0] i, input logic b);
        logic [WIDTH-1:0] r;
        r    = v;
        r[i] = b;
        return r;
    endfunction : put_bit

    sas_state_t        state;
    logic [IW-1:0]     idx;
    logic              phase;
    logic [WIDTH-1:0]  sar;
    logic [WIDTH-1:0]  fill;

    wire [WIDTH-1:0] resolved = put_bit(sar, idx, comp);
    wire             last     = (idx == TOP) ? 1'b0 : sar[idx + 1'b1];

    // Half BIT_CONV_PERIOD of hold, two halves per bit, two closing halves: 23 halves in all.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= SAS_IDLE;
            idx   <= TOP;
            phase <= 1'b0;
            sar   <= '0;
            trial <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                state <= SAS_IDLE;
                trial <= '0;
            end else begin
                unique case (state)
                    SAS_IDLE: if (start) begin
                        state <= SAS_HOLD;
                        sar   <= '0;
                    end
                    SAS_HOLD: if (half_tick) begin
                        state <= SAS_BITS;
                        idx   <= TOP;
                        phase <= 1'b0;
                        trial <= put_bit('0, TOP, 1'b1);
                    end
                    SAS_BITS: if (half_tick) begin
                        phase <= ~phase;
                        if (phase) begin
                            sar <= resolved;
                            if (idx == '0) begin
                                state <= SAS_FINAL;
                                trial <= resolved;
                            end else begin
                                idx   <= idx - 1'b1;
                                trial <= put_bit(resolved, idx - 1'b1, 1'b1);
                            end
                        end
                    end
                    SAS_FINAL: if (half_tick) begin
                        phase <= ~phase;
                        if (phase) begin
                            state <= SAS_IDLE;
                            done  <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    always_comb begin
        fill = sar;
        if (state == SAS_BITS) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (IW'(i) <= idx) begin
                    fill[i] = last;
                end
            end
        end else if (state == SAS_HOLD) begin
            fill = '0;
        end
    end

    assign value  = fill;
    assign busy   = (state != SAS_IDLE);
    assign sample = (state == SAS_IDLE);

endmodule : sas_sar

// [logic/sas_top.sv]
// Converter sequencer top: Avalon-MM registers, sleep handling and analog control.
`timescale 1ns/100ps
`include "sas_defs.svh"
module sas_top
    import sas_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        sleep_mode,
    input  wire logic        rc_clk_pin,
    input  wire logic        comp_pin,
    output sas_ana_t         ana,
    output logic             irq_request,
    output logic             wake_request,
    output logic             irq_vector
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function automatic logic [13:0] chan_decode(input logic [4:0] ch);
        logic [13:0] sel;
        sel = 14'h0000;
        if (ch < `SAS_CH_PINS) begin
            sel = 14'h0001 << ch;
        end else if (ch == `SAS_CH_TEMP) begin
            sel = 14'h1000;
        end else if (ch == `SAS_CH_REFBUF) begin
            sel = 14'h2000;
        end
        return sel;
    endfunction : chan_decode

    function automatic sas_result_t justify(input logic [9:0] v, input logic right);
        sas_result_t r;
        if (right) begin
            r.high = {6'h00, v[9:8]};
            r.low  = v[7:0];
        end else begin
            r.high = v[9:2];
            r.low  = {v[1:0], 6'h00};
        end
        return r;
    endfunction : justify

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic        module_on;
    logic        go;
    logic [4:0]  channel_select;
    logic        pos_ref_select;
    logic [2:0]  conv_clock_select;
    logic        result_justify;
    sas_result_t result;
    logic        conv_complete_flag;
    logic        conv_complete_enable;
    logic        global_irq_enable;
    logic        periph_irq_enable;
    logic        halted;
    logic        sleep_q;
    logic        served;

    // ------------------------------------------------------------------------
    // Synchronisers for the analog comparator and the RC oscillator
    // ------------------------------------------------------------------------
    logic comp_s1;
    logic comp_s2;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            rc_s1   <= 1'b0;
            rc_s2   <= 1'b0;
            rc_s3   <= 1'b0;
        end else begin
            comp_s1 <= comp_pin;
            comp_s2 <= comp_s1;
            rc_s1   <= rc_clk_pin;
            rc_s2   <= rc_s1;
            rc_s3   <= rc_s2;
        end
    end

    // Both RC edges count, so each edge is one half of a bit period.
    wire rc_edge = rc_s2 ^ rc_s3;

    // ------------------------------------------------------------------------
    // Avalon-MM decode
    // ------------------------------------------------------------------------
    // Every access takes one wait state; writes land on the edge that ends the cycle after it.
    wire        req      = avs_read | avs_write;
    wire        wr_ok    = avs_write & served & avs_byteenable[0];
    wire [7:0]  wd       = avs_writedata[7:0];
    wire        wr_ctrl  = wr_ok & (avs_address == `SAS_OFF_CTRL);
    wire        wr_cfg   = wr_ok & (avs_address == `SAS_OFF_CFG);
    wire        wr_irq   = wr_ok & (avs_address == `SAS_OFF_IRQ);

    assign avs_waitrequest = req & ~served;

    // ------------------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------------------
    wire        rc_sel     = (conv_clock_select[1:0] == 2'b11);
    wire        busy;
    wire        done;
    wire        sar_sample;
    wire [9:0]  sar_trial;
    wire [9:0]  sar_value;
    wire        half_tick;

    wire        sleep_rise = sleep_mode & ~sleep_q;
    wire        sleep_kill = sleep_rise & ~rc_sel;
    wire        powered    = module_on & ~halted;
    wire        start      = wr_ctrl & wd[`SAS_CTRL_GO] & wd[`SAS_CTRL_ON]
                             & ~go & ~halted;
    wire        sw_abort   = wr_ctrl & ~wd[`SAS_CTRL_GO] & go & busy;
    wire        off_abort  = wr_ctrl & ~wd[`SAS_CTRL_ON] & busy;
    wire        abort      = sw_abort | off_abort | sleep_kill;
    wire        clk_run    = busy & powered & (~sleep_mode | rc_sel);
    wire        sleep_off  = done & sleep_mode & ~conv_complete_enable;

    logic next_go;
    always_comb begin
        next_go = go;
        if (wr_ctrl) begin
            next_go = start | (go & wd[`SAS_CTRL_GO] & wd[`SAS_CTRL_ON]);
        end
        if (done || sleep_kill) begin
            next_go = 1'b0;
        end
    end

    sas_clkdiv u_clkdiv (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .run       (clk_run),
        .clk_sel   (conv_clock_select),
        .rc_edge   (rc_edge),
        .half_tick (half_tick)
    );

    sas_sar #(
        .WIDTH (10)
    ) u_sar (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .half_tick (half_tick),
        .start     (start),
        .abort     (abort),
        .comp      (comp_s2),
        .busy      (busy),
        .done      (done),
        .sample    (sar_sample),
        .trial     (sar_trial),
        .value     (sar_value)
    );

    // ------------------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            module_on         <= 1'b0;
            go                <= 1'b0;
            channel_select    <= 5'h00;
            pos_ref_select    <= 1'b0;
            conv_clock_select <= 3'h0;
            result_justify    <= 1'b0;
            sleep_q           <= 1'b0;
            halted            <= 1'b0;
        end else begin
            go      <= next_go;
            sleep_q <= sleep_mode;
            if (wr_ctrl) begin
                module_on      <= wd[`SAS_CTRL_ON];
                channel_select <= wd[`SAS_CTRL_CH_HI:`SAS_CTRL_CH_LO];
            end
            if (wr_cfg) begin
                pos_ref_select    <= wd[`SAS_CFG_PREF];
                conv_clock_select <= wd[`SAS_CFG_CS_HI:`SAS_CFG_CS_LO];
                result_justify    <= wd[`SAS_CFG_JUSTIFY];
            end
            // The converter stays off only until the core leaves Sleep.
            if (!sleep_mode) begin
                halted <= 1'b0;
            end else if (sleep_kill || sleep_off) begin
                halted <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Result and completion flag
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            result               <= '0;
            conv_complete_flag   <= 1'b0;
            conv_complete_enable <= 1'b0;
            global_irq_enable    <= 1'b0;
            periph_irq_enable    <= 1'b0;
        end else begin
            if (done || sw_abort) begin
                result <= justify(sar_value, result_justify);
            end
            if (done) begin
                conv_complete_flag <= 1'b1;
            end else if (wr_irq && wd[`SAS_IRQ_FLAG]) begin
                conv_complete_flag <= 1'b0;
            end
            if (wr_irq) begin
                conv_complete_enable <= wd[`SAS_IRQ_EN];
                global_irq_enable    <= wd[`SAS_IRQ_GIE];
                periph_irq_enable    <= wd[`SAS_IRQ_PERIPH_IRQ_ENABLE];
            end
        end
    end

    assign irq_request  = conv_complete_flag & conv_complete_enable;
    assign wake_request = irq_request & sleep_mode;
    assign irq_vector   = irq_request & global_irq_enable & periph_irq_enable;

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    wire [7:0] rd_ctrl = {1'b0, channel_select, go, module_on};
    wire [7:0] rd_cfg  = {result_justify, conv_clock_select, 3'h0, pos_ref_select};
    wire [7:0] rd_irq  = {4'h0, periph_irq_enable, global_irq_enable,
                          conv_complete_enable, conv_complete_flag};
    logic [7:0] rd_mux;

    always_comb begin
        unique case (avs_address)
            `SAS_OFF_CTRL:     rd_mux = rd_ctrl;
            `SAS_OFF_CFG:      rd_mux = rd_cfg;
            `SAS_OFF_RES_HIGH: rd_mux = result.high;
            `SAS_OFF_RES_LOW:  rd_mux = result.low;
            `SAS_OFF_IRQ:      rd_mux = rd_irq;
            default:           rd_mux = `SAS_RST_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            served       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            served <= req & ~served;
            if (avs_read && !served) begin
                avs_readdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Analog side
    // ------------------------------------------------------------------------
    // Trial and select only flip on flop edges, so the analog side sees no glitches.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ana <= '0;
        end else begin
            ana.powered <= powered;
            ana.sample  <= powered & sar_sample;
            ana.mux_sel <= powered ? chan_decode(channel_select) : 14'h0000;
            ana.ref_ext <= pos_ref_select;
            ana.trial   <= sar_trial;
        end
    end

endmodule : sas_top

// [dv/sas_props.sv]
// Port-level checker for the converter sequencer top.
`timescale 1ns/100ps
module sas_props
    import sas_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        sleep_mode,
    input wire sas_ana_t    ana,
    input wire logic        irq_request,
    input wire logic        wake_request,
    input wire logic        irq_vector
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_wake_in_sleep: assert property (wake_request == (irq_request && sleep_mode))
        else $error("wake request wrong");
    a_vector_gated: assert property (irq_vector |-> irq_request)
        else $error("vector without request");
    a_mux_single: assert property ($onehot0(ana.mux_sel))
        else $error("several sources selected");
    a_reset_quiet: assert property ($rose(resetn) |-> !ana.powered && !irq_request)
        else $error("busy after reset");
    a_first_trial: assert property ($changed(ana.trial) && $past(ana.trial) == 10'h000 |-> ana.trial == 10'h200)
        else $error("first trial not msb");
    // The flag may only drop through a software write to the interrupt register.
    a_flag_held: assert property ($fell(irq_request) |-> $past(avs_write) && $past(avs_address) == 5'h10)
        else $error("flag dropped alone");
    a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait state count");
    c_done: cover property ($rose(irq_request));
    c_wake: cover property ($rose(wake_request));
    c_vector: cover property ($rose(irq_vector));
    c_halt: cover property ($fell(ana.powered) && sleep_mode);
endmodule : sas_props
bind sas_top sas_props u_props (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .sleep_mode, .ana, .irq_request, .wake_request, .irq_vector);

// [dv/sas_comp_model.sv]
// Behavioural sample-and-hold and comparator facing the sequencer.
`timescale 1ns/100ps
module sas_comp_model
    import sas_pkg::*;
(
    input wire logic       sys_clk,
    input wire sas_ana_t   ana,
    input wire logic [9:0] level,
    output logic           comp_pin
);
    logic [9:0] held = 10'h000;
    logic       junk = 1'b0;
    always @(posedge sys_clk) begin
        junk <= ~junk;
        if (ana.sample) begin
            held <= level;
        end
    end
    // Unpowered, the output wanders so a stale compare cannot pass for a real one.
    assign comp_pin = ana.powered ? (held >= ana.trial) : junk;
endmodule : sas_comp_model

// [dv/tb_sar_adc_sequencer.sv]
// Self-checking bench of the converter sequencer top.
`timescale 1ns/100ps
`include "sas_defs.svh"
module tb_sar_adc_sequencer
    import sas_pkg::*;
;
    logic        sys_clk, resetn, avs_read, avs_write, sleep_mode, rc_clk_pin, comp_pin;
    logic        avs_waitrequest, irq_request, wake_request, irq_vector;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [9:0]  level;
    logic [7:0]  hi;
    sas_ana_t    ana;
    int          fails, num_checks, cnt, seed, t_w, m, h;
    sas_top dut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .sleep_mode, .rc_clk_pin, .comp_pin,
        .ana, .irq_request, .wake_request, .irq_vector);
    sas_comp_model u_comp (.sys_clk, .ana, .level, .comp_pin);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        rc_clk_pin = 1'b0;
        forever #170 rc_clk_pin = ~rc_clk_pin;
    end
    always @(posedge sys_clk) begin
        cnt <= cnt + 1;
        if (cnt == 20000) begin
            fails++;
            print_verdict;
        end
    end
    task print_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        t_w = cnt;
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) fails++;
    endtask : bus
    task start(input logic [2:0] c, input logic j, input logic [4:0] ch);
        bus(1'b1, 5'h04, {j, c, 4'h0});
        bus(1'b1, 5'h00, {1'b0, ch, 2'b01});
        repeat (ch == `SAS_CH_TEMP ? `SAS_TEMP_SETTLE_CYC : 4) @(posedge sys_clk);
        bus(1'b1, 5'h00, {1'b0, ch, 2'b11});
    endtask : start
    task wait_done;
        int t0;
        t0 = t_w;
        m = 0;
        do begin
            bus(1'b0, 5'h00, 8'h00);
            m++;
        end while (rdata[1] !== 1'b0 && m < 400);
        m = t_w - t0;
    endtask : wait_done
    function automatic logic [13:0] exp_mux(input logic [4:0] c);
        return c < 5'h0C ? 14'h0001 << c : c == 5'h1D ? 14'h1000 : c == 5'h1E ? 14'h2000 : 14'h0000;
    endfunction : exp_mux
    // Half-tick length in clocks; zero stands for the free-running RC source.
    function automatic int half(input logic [2:0] c);
        return c[1:0] == 2'b11 ? 0 : 1 << {c[1], c[0], c[2]};
    endfunction : half
    initial begin
        {resetn, avs_read, avs_write, sleep_mode, avs_address, avs_writedata, level} = '0;
        {fails, num_checks, cnt} = '0;
        seed = 29;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 24; a += 4) begin
            bus(1'b0, 5'(a), 8'h00);
            chk(rdata, 0);
        end
        $display("test 1 end");
        for (int c = 0; c < 32; c++) begin
            bus(1'b1, 5'h00, {1'b0, 5'(c), 2'b01});
            repeat (2) @(negedge sys_clk);
            chk(32'(ana.mux_sel), 32'(exp_mux(5'(c))));
        end
        bus(1'b1, 5'h04, 8'h01);
        repeat (2) @(negedge sys_clk);
        chk(ana.ref_ext, 1);
        $display("test 2 end");
        bus(1'b1, 5'h10, 8'h02);
        for (int i = 0; i < 8; i++) begin
            level <= i == 2 ? 10'h000 : i == 5 ? 10'h3FF : 10'($random(seed));
            start(3'(i), i[0], 5'(i));
            wait_done;
            h = half(3'(i));
            if (h > 0) chk(m >= 23 * h && m <= 23 * h + 12, 1);
            bus(1'b0, 5'h08, 8'h00);
            hi = rdata[7:0];
            bus(1'b0, 5'h0C, 8'h00);
            if (h == 0 || h >= 4) chk({hi, rdata[7:0]}, i[0] ? {6'h00, level} : {level, 6'h00});
            chk(irq_request, 1);
            bus(1'b1, 5'h10, 8'h03);
            @(negedge sys_clk);
            chk(irq_request, 0);
        end
        $display("test 3 end");
        level <= 10'h155;
        start(3'b110, 1'b1, 5'h03);
        repeat (200) @(posedge sys_clk);
        bus(1'b1, 5'h00, {1'b0, 5'h03, 2'b01});
        bus(1'b0, 5'h08, 8'h00);
        chk(rdata, {6'h00, level[9:8]});
        bus(1'b0, 5'h0C, 8'h00);
        chk(rdata, {8{level[8]}});
        chk(irq_request, 0);
        start(3'b110, 1'b0, 5'h02);
        repeat (100) @(posedge sys_clk);
        resetn <= 1'b0;
        @(posedge sys_clk);
        resetn <= 1'b1;
        bus(1'b0, 5'h00, 8'h00);
        chk(rdata, 0);
        bus(1'b0, 5'h0C, 8'h00);
        chk(rdata, 0);
        $display("test 4 end");
        start(3'b110, 1'b0, 5'h04);
        repeat (20) @(posedge sys_clk);
        sleep_mode <= 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(ana.powered, 0);
        bus(1'b0, 5'h00, 8'h00);
        chk(rdata[1:0], 2'b01);
        sleep_mode <= 1'b0;
        $display("test 5 end");
        bus(1'b1, 5'h10, 8'h0E);
        start(3'b011, 1'b1, 5'h1E);
        sleep_mode <= 1'b1;
        m = 0;
        while (wake_request !== 1'b1 && m < 400) begin
            @(negedge sys_clk);
            m++;
        end
        chk({wake_request, irq_vector}, 2'b11);
        bus(1'b1, 5'h10, 8'h03);
        @(negedge sys_clk);
        chk(irq_vector, 0);
        bus(1'b1, 5'h10, 8'h01);
        start(3'b111, 1'b0, 5'h1D);
        wait_done;
        @(negedge sys_clk);
        chk({ana.powered, rdata[0]}, 2'b01);
        sleep_mode <= 1'b0;
        $display("test 6 end");
        print_verdict;
    end
endmodule : tb_sar_adc_sequencer
